/* hw/isp_test_port.sv */
// ISP test port: command decoding, extension pins, security and sector protection.
`timescale 1ns/100ps
`include "isp_port_map.svh"
module isp_test_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nvm_test_dedicate,
  input  wire logic        test_pin_select_term,
  input  wire logic        chip_reset_n,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  input  wire logic        flash_fail,
  input  wire logic        boot_write,
  output logic             test_pins_on,
  output logic             readout_allowed,
  output logic             isp_error_pin,
  output logic             isp_error_pin_oe,
  output logic             isp_status_pin,
  output logic             isp_status_pin_oe,
  output logic             ext_pins_active
);

  // Pin inputs pass two flip-flops; stage one feeds only stage two.
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 5'h10;
      sync_b <= 5'h10;
    end else begin
      sync_a <= {chip_reset_n, test_pin_select_term, tck, tms, tdi};
      sync_b <= sync_a;
    end
  end
  logic s_tdi, s_tms, s_tck, s_term, s_rst_n;
  assign {s_rst_n, s_term, s_tck, s_tms, s_tdi} = sync_b;

  logic tck_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= s_tck;
    end
  end
  logic tck_rise, tck_fall;
  assign tck_rise = s_tck & ~tck_d;
  assign tck_fall = ~s_tck & tck_d;

  // APB register state.
  logic        test_enable, next_test_enable;
  logic [1:0]  ext_od_sw, next_ext_od_sw;
  logic [15:0] sector_prot, next_sector_prot;
  logic        secured, next_secured;

  logic hold_reset;
  // The strap dedicates the pins; only then is the chip reset ignored.
  assign hold_reset   = ~s_rst_n & ~nvm_test_dedicate;
  assign test_pins_on = nvm_test_dedicate | test_enable | s_term;

  logic wr_acc, rd_acc, hit;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign hit     = (paddr == `ADDR_TEST_ENABLE) || (paddr == `ADDR_EXT_CTRL) ||
                   (paddr == `ADDR_ISP_STATUS) || (paddr == `ADDR_SECTOR_PROT) ||
                   (paddr == `ADDR_SECURITY);
  assign pslverr = psel & penable & ~hit;

  // TAP and ISP engine state.
  isp_port_pkg::tap_state_e tap, next_tap;
  logic [`IR_LEN-1:0] ir_sh, next_ir_sh, ir, next_ir;
  logic [15:0]        dr_sh, next_dr_sh;
  logic               isp_on, next_isp_on;
  logic               disabled_seen, next_disabled_seen;
  logic               err, next_err;
  logic               busy, next_busy;
  logic               erasing_chip, next_erasing_chip;
  logic [7:0]         op_cnt, next_op_cnt;
  logic               od_jtag, next_od_jtag;
  logic               tdo_q, next_tdo_q;

  function automatic logic locked_out(input logic [`IR_LEN-1:0] code, input logic sec);
    locked_out = sec && (code == `INS_PROGRAM || code == `INS_SECTOR_ERASE ||
                         code == `INS_VERIFY);
  endfunction : locked_out

  always_comb begin
    next_tap           = tap;
    next_ir_sh         = ir_sh;
    next_ir            = ir;
    next_dr_sh         = dr_sh;
    next_isp_on        = isp_on;
    next_disabled_seen = disabled_seen;
    next_err           = err;
    next_busy          = busy;
    next_erasing_chip  = erasing_chip;
    next_op_cnt        = op_cnt;
    next_od_jtag       = od_jtag;
    next_tdo_q         = tdo_q;
    next_test_enable   = test_enable;
    next_ext_od_sw     = ext_od_sw;
    next_sector_prot   = sector_prot;
    next_secured       = secured;
    if (wr_acc) begin
      case (paddr)
        `ADDR_TEST_ENABLE: next_test_enable = pwdata[`BIT_TEST_ENABLE];
        `ADDR_EXT_CTRL:    next_ext_od_sw   = pwdata[1:0];
        `ADDR_SECTOR_PROT: next_sector_prot = pwdata[15:0];
        `ADDR_SECURITY:    next_secured     = secured | pwdata[0];
        default:           next_test_enable = test_enable;
      endcase
    end
    if (busy) begin
      if (op_cnt == 8'h00) begin
        next_busy = 1'b0;
        if (erasing_chip) begin
          next_secured      = wr_acc && (paddr == `ADDR_SECURITY) && pwdata[0];
          next_sector_prot  = `RST_SECTOR_PROT;
          next_erasing_chip = 1'b0;
        end
      end else begin
        next_op_cnt = op_cnt - 8'h01;
      end
      if (flash_fail) begin
        next_err = 1'b1;
      end
    end
    if (test_pins_on && tck_fall) begin
      next_tdo_q = (tap == isp_port_pkg::TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
    end
    if (test_pins_on && tck_rise) begin
      case (tap)
        isp_port_pkg::TAP_RESET:  next_tap = s_tms ? isp_port_pkg::TAP_RESET
                                                   : isp_port_pkg::TAP_IDLE;
        isp_port_pkg::TAP_IDLE:   next_tap = s_tms ? isp_port_pkg::TAP_SEL_DR
                                                   : isp_port_pkg::TAP_IDLE;
        isp_port_pkg::TAP_SEL_DR: next_tap = s_tms ? isp_port_pkg::TAP_SEL_IR
                                                   : isp_port_pkg::TAP_CAP_DR;
        isp_port_pkg::TAP_CAP_DR: begin
          // Readout of a secured part captures zeros.
          next_dr_sh = secured ? 16'h0000 : {11'h000, busy, err, secured, isp_on, 1'b1};
          next_tap   = s_tms ? isp_port_pkg::TAP_EX1_DR : isp_port_pkg::TAP_SH_DR;
        end
        isp_port_pkg::TAP_SH_DR: begin
          next_dr_sh = {s_tdi, dr_sh[15:1]};
          next_tap   = s_tms ? isp_port_pkg::TAP_EX1_DR : isp_port_pkg::TAP_SH_DR;
        end
        isp_port_pkg::TAP_EX1_DR: next_tap = s_tms ? isp_port_pkg::TAP_UP_DR
                                                   : isp_port_pkg::TAP_PA_DR;
        isp_port_pkg::TAP_PA_DR:  next_tap = s_tms ? isp_port_pkg::TAP_EX2_DR
                                                   : isp_port_pkg::TAP_PA_DR;
        isp_port_pkg::TAP_EX2_DR: next_tap = s_tms ? isp_port_pkg::TAP_UP_DR
                                                   : isp_port_pkg::TAP_SH_DR;
        isp_port_pkg::TAP_UP_DR: begin
          next_tap = s_tms ? isp_port_pkg::TAP_SEL_DR : isp_port_pkg::TAP_IDLE;
          if (isp_on && !busy && !locked_out(ir, secured)) begin
            case (ir)
              `INS_PROGRAM: begin
                next_busy   = 1'b1;
                next_op_cnt = 8'(`OP_CYCLES);
              end
              `INS_SECTOR_ERASE: begin
                if (sector_prot[dr_sh[3:0]]) begin
                  next_err = 1'b1;
                end else begin
                  next_busy   = 1'b1;
                  next_op_cnt = 8'(`OP_CYCLES);
                end
              end
              `INS_CHIP_ERASE: begin
                next_busy         = 1'b1;
                next_erasing_chip = 1'b1;
                next_op_cnt       = 8'(`OP_CYCLES);
              end
              default: next_busy = busy;
            endcase
          end
        end
        isp_port_pkg::TAP_SEL_IR: next_tap = s_tms ? isp_port_pkg::TAP_RESET
                                                   : isp_port_pkg::TAP_CAP_IR;
        isp_port_pkg::TAP_CAP_IR: begin
          next_ir_sh = `IR_LEN'(1);
          next_tap   = s_tms ? isp_port_pkg::TAP_EX1_IR : isp_port_pkg::TAP_SH_IR;
        end
        isp_port_pkg::TAP_SH_IR: begin
          next_ir_sh = {s_tdi, ir_sh[`IR_LEN-1:1]};
          next_tap   = s_tms ? isp_port_pkg::TAP_EX1_IR : isp_port_pkg::TAP_SH_IR;
        end
        isp_port_pkg::TAP_EX1_IR: next_tap = s_tms ? isp_port_pkg::TAP_UP_IR
                                                   : isp_port_pkg::TAP_PA_IR;
        isp_port_pkg::TAP_PA_IR:  next_tap = s_tms ? isp_port_pkg::TAP_EX2_IR
                                                   : isp_port_pkg::TAP_PA_IR;
        isp_port_pkg::TAP_EX2_IR: next_tap = s_tms ? isp_port_pkg::TAP_UP_IR
                                                   : isp_port_pkg::TAP_SH_IR;
        isp_port_pkg::TAP_UP_IR: begin
          next_tap = s_tms ? isp_port_pkg::TAP_SEL_DR : isp_port_pkg::TAP_IDLE;
          next_ir  = ir_sh;
          case (ir_sh)
            `INS_ENABLE: begin
              next_isp_on        = 1'b1;
              next_disabled_seen = 1'b0;
            end
            `INS_DISABLE: begin
              next_isp_on        = 1'b0;
              next_disabled_seen = 1'b1;
            end
            `INS_CLEAR_ERR: next_err = 1'b0;
            `INS_EXT_OD:    next_od_jtag = isp_on & ~secured;
            default:        next_ir = ir_sh;
          endcase
        end
        default: next_tap = isp_port_pkg::TAP_RESET;
      endcase
    end
    if (busy && flash_fail) begin
      next_err = 1'b1;
    end
    if (!test_pins_on || tap == isp_port_pkg::TAP_RESET && s_tms && tck_rise) begin
      next_tap = isp_port_pkg::TAP_RESET;
    end
    if (hold_reset) begin
      next_tap         = isp_port_pkg::TAP_RESET;
      next_isp_on      = 1'b0;
      next_test_enable = 1'b0;
      if (disabled_seen && !(busy && flash_fail)) begin
        next_err = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap           <= isp_port_pkg::TAP_RESET;
      ir_sh         <= `IR_LEN'(0);
      ir            <= `INS_BYPASS;
      dr_sh         <= 16'h0000;
      isp_on        <= 1'b0;
      disabled_seen <= 1'b0;
      err           <= 1'b0;
      busy          <= 1'b0;
      erasing_chip  <= 1'b0;
      op_cnt        <= 8'h00;
      od_jtag       <= 1'b0;
      tdo_q         <= 1'b0;
      test_enable   <= 1'b0;
      ext_od_sw     <= 2'h0;
      sector_prot   <= `RST_SECTOR_PROT;
      secured       <= `RST_SECURITY;
    end else begin
      tap           <= next_tap;
      ir_sh         <= next_ir_sh;
      ir            <= next_ir;
      dr_sh         <= next_dr_sh;
      isp_on        <= next_isp_on;
      disabled_seen <= next_disabled_seen;
      err           <= next_err;
      busy          <= next_busy;
      erasing_chip  <= next_erasing_chip;
      op_cnt        <= next_op_cnt;
      od_jtag       <= next_od_jtag;
      tdo_q         <= next_tdo_q;
      test_enable   <= next_test_enable;
      ext_od_sw     <= next_ext_od_sw;
      sector_prot   <= next_sector_prot;
      secured       <= next_secured;
    end
  end

  // Pin drive; open-drain mode drives only the low level.
  logic od_err, od_stat;
  isp_port_pkg::pin_drive_s err_drv, stat_drv;
  assign od_err  = od_jtag | ext_od_sw[`BIT_EXT_ERR_OD];
  assign od_stat = od_jtag | ext_od_sw[`BIT_EXT_STAT_OD];
  assign ext_pins_active = isp_on & test_pins_on;
  assign err_drv.out  = ~err;
  assign err_drv.oe   = ext_pins_active & (od_err ? err : 1'b1);
  assign stat_drv.out = ~(busy | boot_write);
  assign stat_drv.oe  = ext_pins_active & (od_stat ? stat_drv.out == 1'b0 : 1'b1);
  assign isp_error_pin     = err_drv.out;
  assign isp_error_pin_oe  = err_drv.oe;
  assign isp_status_pin    = stat_drv.out;
  assign isp_status_pin_oe = stat_drv.oe;
  assign tdo             = tdo_q;
  assign tdo_oe          = ext_pins_active;
  assign readout_allowed = ~secured;

  always_comb begin
    prdata = 32'h00000000;
    if (rd_acc) begin
      case (paddr)
        `ADDR_TEST_ENABLE: prdata = {31'h0, test_enable};
        `ADDR_EXT_CTRL:    prdata = {30'h0, ext_od_sw};
        `ADDR_ISP_STATUS:  prdata = {28'h0, busy, err, secured, isp_on};
        `ADDR_SECTOR_PROT: prdata = {16'h0, sector_prot};
        `ADDR_SECURITY:    prdata = {31'h0, secured};
        default:           prdata = 32'h00000000;
      endcase
    end
  end

endmodule : isp_test_port

/* hw/isp_port_map.svh */
// Offsets, field positions, reset values and timing counts for the ISP test port.
`ifndef ISP_PORT_MAP_SVH
`define ISP_PORT_MAP_SVH
`define ADDR_TEST_ENABLE   12'h0c4
`define ADDR_EXT_CTRL      12'h000
`define ADDR_ISP_STATUS    12'h004
`define ADDR_SECTOR_PROT   12'h008
`define ADDR_SECURITY      12'h00c
`define BIT_TEST_ENABLE    0
`define BIT_EXT_ERR_OD     0
`define BIT_EXT_STAT_OD    1
`define RST_SECTOR_PROT    16'h0000
`define RST_SECURITY       1'b0
`define OP_TIME_NS         4000
`define CLK_PERIOD_NS      40
`define OP_CYCLES          ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IR_LEN             4
`define INS_ENABLE         4'h1
`define INS_DISABLE        4'h2
`define INS_PROGRAM        4'h3
`define INS_SECTOR_ERASE   4'h4
`define INS_CHIP_ERASE     4'h5
`define INS_VERIFY         4'h6
`define INS_CLEAR_ERR      4'h7
`define INS_EXT_OD         4'h8
`define INS_BYPASS         4'hf
`endif

/* hw/isp_port_pkg.sv */
// Types shared by the ISP test port.
package isp_port_pkg;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } tap_state_e;
  typedef struct packed {
    logic       out;
    logic       oe;
  } pin_drive_s;
  typedef struct packed {
    logic       busy;
    logic       error;
    logic       secured;
    logic       isp_on;
  } isp_state_s;
endpackage : isp_port_pkg

/* tb/jtag_ctl.sv */
// Behavioural test-link controller that drives the ISP test port.
`timescale 1ns/100ps
module jtag_ctl (
  input  wire logic pclk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // The link clock rests low between frames, as a real cable leaves it.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One link cycle is 8 pclk; tdo is sampled mid high phase, clear of its falling-edge update.
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    repeat (2) @(posedge pclk);
    o = tdo;
    repeat (2) @(posedge pclk);
    tck <= 1'b0;
  endtask : step
  // Every instruction, the enabling and the open-drain one too, is loaded here.
  task automatic scan(input logic ir, input logic [15:0] v, input int n, output logic [15:0] c);
    logic o;
    c = 16'h0000;
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      c[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : scan
endmodule : jtag_ctl

/* tb/isp_test_port_sva.sv */
// Concurrent checks on the ports of the ISP test port.
`timescale 1ns/100ps
module isp_test_port_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        nvm_test_dedicate,
  input wire logic        test_pin_select_term,
  input wire logic        flash_fail,
  input wire logic        boot_write,
  input wire logic        tdo_oe,
  input wire logic        test_pins_on,
  input wire logic        readout_allowed,
  input wire logic        isp_error_pin,
  input wire logic        isp_error_pin_oe,
  input wire logic        isp_status_pin,
  input wire logic        isp_status_pin_oe,
  input wire logic        ext_pins_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_acc = psel && penable && !pwrite;
  a_secure_reg:
    assert property (rd_acc && paddr == 12'h00c |-> prdata[0] == !readout_allowed)
    else $error("security bit and readout gate disagree");
  a_secure_stat:
    assert property (rd_acc && paddr == 12'h004 |-> prdata[1] == !readout_allowed)
    else $error("status secured bit and readout gate disagree");
  a_strap_on:
    assert property (nvm_test_dedicate |-> test_pins_on) else $error("strap did not enable pins");
  a_term_on:
    assert property (test_pin_select_term [*4] |-> test_pins_on)
    else $error("select term did not enable pins");
  a_tdo_quiet:
    assert property (!test_pins_on [*4] |-> !tdo_oe) else $error("tdo driven with pins off");
  a_ext_idle:
    assert property (!ext_pins_active |-> !isp_error_pin_oe && !isp_status_pin_oe)
    else $error("extension pin driven while inactive");
  a_boot_busy:
    assert property (ext_pins_active && boot_write [*3] |-> !isp_status_pin)
    else $error("status high during boot write");
  a_fail_flag:
    assert property (ext_pins_active && !isp_status_pin && !boot_write && flash_fail
      |-> ##[1:4] !isp_error_pin) else $error("failure not flagged");
  a_error_drive:
    assert property (ext_pins_active && !isp_error_pin |-> isp_error_pin_oe)
    else $error("error level not driven");
  c_busy: cover property ($fell(isp_status_pin));
  c_error: cover property ($fell(isp_error_pin));
  c_secure: cover property ($fell(readout_allowed));
endmodule : isp_test_port_sva

/* tb/isp_test_port_tb.sv */
// Self-checking bench for the ISP test port.
`timescale 1ns/100ps
`include "isp_port_map.svh"
module isp_test_port_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo;
  logic        nvm_test_dedicate, test_pin_select_term, chip_reset_n, flash_fail, boot_write;
  logic        tdo_oe, test_pins_on, readout_allowed, ext_pins_active, slv;
  logic        isp_error_pin, isp_error_pin_oe, isp_status_pin, isp_status_pin_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cap;
  int          bad_count, compares;
  isp_test_port u_isp_test_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_test_dedicate(nvm_test_dedicate), .test_pin_select_term(test_pin_select_term),
    .chip_reset_n(chip_reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .flash_fail(flash_fail), .boot_write(boot_write),
    .test_pins_on(test_pins_on), .readout_allowed(readout_allowed),
    .isp_error_pin(isp_error_pin), .isp_error_pin_oe(isp_error_pin_oe),
    .isp_status_pin(isp_status_pin), .isp_status_pin_oe(isp_status_pin_oe),
    .ext_pins_active(ext_pins_active)
  );
  jtag_ctl u_jtag_ctl (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task automatic chk1(input string s, input logic e, input logic g);
    check(s, {31'h0, e}, {31'h0, g});
  endtask : chk1
  // The slave holds pready high; pready or the 50-cycle bound ends a wait.
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
  endtask : rw
  task automatic wait_ready();
    int n;
    n = 0;
    while (isp_status_pin !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      wrap_up();
    end
  endtask : wait_ready
  task automatic op(input logic [3:0] ins, input logic [15:0] d);
    u_jtag_ctl.scan(1'b1, {12'h000, ins}, 4, cap);
    u_jtag_ctl.scan(1'b0, d, 16, cap);
  endtask : op
  task automatic pulse_reset();
    chip_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chip_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : pulse_reset
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, nvm_test_dedicate} = '0;
    {test_pin_select_term, flash_fail, boot_write} = '0;
    chip_reset_n = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rw(0, 12'h008, 0); check("protect", 0, rd);
    rw(0, 12'h00c, 0); check("security", 0, rd);
    rw(0, 12'h010, 0); chk1("unmapped", 1, slv);
    chk1("pins", 0, test_pins_on);
    chk1("ext", 0, ext_pins_active);
    test_pin_select_term <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1("term pins", 1, test_pins_on);
    test_pin_select_term <= 1'b0;
    rw(1, 12'h0c4, 1); chk1("bit pins", 1, test_pins_on);
    chk1("tdo oe", 0, tdo_oe);
    u_jtag_ctl.scan(1'b1, `INS_ENABLE, 4, cap); check("ir cap", 1, cap[3:0]);
    repeat (4) @(posedge pclk);
    chk1("tdo oe", 1, tdo_oe);
    chk1("ext", 1, ext_pins_active);
    chk1("stat", 1, isp_status_pin);
    chk1("stat oe", 1, isp_status_pin_oe);
    u_jtag_ctl.scan(1'b0, 0, 16, cap); check("dr cap", 3, cap);
    boot_write <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1("boot stat", 0, isp_status_pin);
    boot_write <= 1'b0;
    flash_fail <= 1'b1;
    op(`INS_PROGRAM, 0); chk1("prog stat", 0, isp_status_pin);
    wait_ready();
    flash_fail <= 1'b0;
    chk1("err", 0, isp_error_pin);
    rw(0, 12'h004, 0); check("status", 5, rd);
    op(`INS_CLEAR_ERR, 0); chk1("err", 1, isp_error_pin);
    rw(1, 12'h008, 4);
    op(`INS_SECTOR_ERASE, 2); chk1("prot err", 0, isp_error_pin);
    chk1("prot stat", 1, isp_status_pin);
    op(`INS_CLEAR_ERR, 0);
    op(`INS_SECTOR_ERASE, 3); chk1("erase stat", 0, isp_status_pin);
    wait_ready();
    chk1("erase err", 1, isp_error_pin);
    rw(1, 12'h00c, 1); chk1("readout", 0, readout_allowed);
    op(`INS_PROGRAM, 0); check("secure cap", 0, cap);
    chk1("blocked stat", 1, isp_status_pin);
    rw(1, 12'h00c, 0);
    rw(0, 12'h00c, 0); check("security", 1, rd);
    op(`INS_CHIP_ERASE, 0); chk1("chip stat", 0, isp_status_pin);
    wait_ready();
    chk1("readout", 1, readout_allowed);
    rw(0, 12'h00c, 0); check("security", 0, rd);
    op(`INS_EXT_OD, 0);
    // The instruction switches the drive only; the software open-drain bits stay clear.
    rw(0, 12'h000, 0); check("open drain", 0, rd);
    chk1("stat oe", 0, isp_status_pin_oe);
    chk1("err oe", 0, isp_error_pin_oe);
    // Chip erase dropped all protection, so sector 2 must be guarded again.
    rw(1, 12'h008, 4);
    op(`INS_SECTOR_ERASE, 2); chk1("err", 0, isp_error_pin);
    chk1("err oe", 1, isp_error_pin_oe);
    op(`INS_DISABLE, 0);
    pulse_reset();
    rw(0, 12'h004, 0); check("err bit", 0, rd & 32'h4);
    chk1("pins", 0, test_pins_on);
    chk1("tdo oe", 0, tdo_oe);
    nvm_test_dedicate <= 1'b1;
    op(`INS_ENABLE, 0);
    pulse_reset();
    chk1("strap pins", 1, test_pins_on);
    chk1("strap tdo", 1, tdo_oe);
    wrap_up();
  end
endmodule : isp_test_port_tb
bind isp_test_port isp_test_port_sva u_isp_test_port_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .nvm_test_dedicate(nvm_test_dedicate),
  .test_pin_select_term(test_pin_select_term), .flash_fail(flash_fail),
  .boot_write(boot_write), .tdo_oe(tdo_oe), .test_pins_on(test_pins_on),
  .readout_allowed(readout_allowed), .isp_error_pin(isp_error_pin),
  .isp_error_pin_oe(isp_error_pin_oe), .isp_status_pin(isp_status_pin),
  .isp_status_pin_oe(isp_status_pin_oe), .ext_pins_active(ext_pins_active)
);
